// File: tb/hbpc_host.sv
// Host CPU model driving the control pins of the host bus port
`timescale 1ns/1ns
`default_nettype none
module hbpc_host
(
    // Clock
    input wire logic i_mclk,
    // Pins toward the device
    output var hbpc_pkg::hbpc_addr_t o_addr,
    output logic o_sync_cycle,
    output logic o_sel,
    output logic o_wr_n,
    output logic o_ads_n
);
    import hbpc_pkg::*;
    // Idle pins: qualifier pulled up, select pulled down
    initial
    begin
        o_addr = ADDR_RST;
        o_sync_cycle = 1'b0;
        o_sel = 1'b0;
        o_wr_n = 1'b1;
        o_ads_n = 1'b0;
    end
    // Released lines change value so a stale address never looks valid
    task automatic drop();
        o_addr <= '{addr: ~o_addr.addr, qual_n: 1'b1};
    endtask
    // Present address and qualifier from the next edge on
    task automatic put(input logic [ADDR_W-1:0] a, input logic q);
        @(posedge i_mclk);
        o_addr <= '{addr: a, qual_n: q};
    endtask
    // Synchronous access, address set up lag cycles early
    task automatic sync_acc(input logic [ADDR_W-1:0] a, input logic q, input logic w,
        input int lag);
        put(a, q);
        repeat (lag) @(posedge i_mclk);
        o_sel <= w;
        o_sync_cycle <= 1'b1;
        @(posedge i_mclk);
        o_sync_cycle <= 1'b0;
        o_sel <= 1'b0;
        drop();
    endtask
    // Async write; address held until the strobe is back high
    task automatic async_wr(input logic [ADDR_W-1:0] a, input int hold);
        put(a, 1'b0);
        o_wr_n <= 1'b0;
        repeat (hold) @(posedge i_mclk);
        o_wr_n <= 1'b1;
        @(posedge i_mclk);
        drop();
    endtask
    // Address valid across the rising latch strobe
    task automatic latch(input logic [ADDR_W-1:0] a, input logic q);
        put(a, q);
        @(posedge i_mclk);
        o_ads_n <= 1'b1;
        @(posedge i_mclk);
        o_ads_n <= 1'b0;
        drop();
    endtask
endmodule
`default_nettype wire

// File: tb/host_bus_pin_control_test.sv
// Self-checking bench for the host bus pin control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module host_bus_pin_control_test;
    import hbpc_pkg::*;
    // Bench-driven pins, host pins and device outputs
    logic i_mclk, i_hw_reset_n, ee_strap, ee_in, b32, latch_mode, pd_n;
    logic [BASE_W-1:0] base;
    hbpc_addr_t addr;
    logic sync_cycle, sel, wr_n, ads_n, sel_n, s_wr, s_rd, a_wr, pd, ee_pres, strap_ok;
    hbpc_width_t width;
    int err_count = 0;
    int n_compared = 0;
    int nw, nr, na;
    // Base A5C0 places the device at A15..A4 = A5C
    localparam logic [ADDR_W-1:0] HIT = {12'hA5C, 3'h5};
    localparam logic [ADDR_W-1:0] MISS = {12'hA5D, 3'h5};
    hbpc_host host (.i_mclk(i_mclk), .o_addr(addr), .o_sync_cycle(sync_cycle), .o_sel(sel),
        .o_wr_n(wr_n), .o_ads_n(ads_n));
    hbpc_top dut (.i_mclk(i_mclk), .i_hw_reset_n(i_hw_reset_n), .i_eeprom_present_strap(ee_strap),
        .i_eeprom_serial_in(ee_in), .i_bus32_strap(b32), .i_latch_mode(latch_mode),
        .i_base_addr(base), .i_addr(addr), .i_sync_cycle(sync_cycle),
        .i_sync_write_read_sel(sel), .i_async_write_strobe_n(wr_n),
        .i_addr_latch_strobe_n(ads_n), .i_chip_powerdown_n(pd_n),
        .o_local_device_select_n(sel_n), .o_sync_wr(s_wr), .o_sync_rd(s_rd),
        .o_async_wr(a_wr), .o_powerdown(pd), .o_bus_width(width),
        .o_eeprom_present(ee_pres), .o_strap_valid(strap_ok));
    // Verdict and end of run
    task automatic test_done();
        if (err_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One access by the host while pulses are counted over six cycles
    task automatic acc(input logic as, input logic [ADDR_W-1:0] a, input logic q,
        input logic w, input int n);
        nw = 0;
        nr = 0;
        na = 0;
        fork
            if (as) host.async_wr(a, n);
            else host.sync_acc(a, q, w, n);
            repeat (6)
            begin
                @(posedge i_mclk);
                #1;
                // Anything but a clean low counts, so an unknown pulse shows up
                nw += int'(s_wr !== 1'b0);
                nr += int'(s_rd !== 1'b0);
                na += int'(a_wr !== 1'b0);
            end
        join
    endtask
    // Reset with given straps; later pin changes must not move the result
    task automatic t_strap(input logic w, input logic e, input logic d, input hbpc_width_t x);
        @(posedge i_mclk);
        i_hw_reset_n <= 1'b0;
        b32 <= w;
        ee_strap <= e;
        ee_in <= d;
        // Hold far short of the board's 10ms: the block times nothing from it
        repeat (20) @(posedge i_mclk);
        i_hw_reset_n <= 1'b1;
        @(posedge i_mclk);
        #1;
        `CHK(strap_ok, 1'b1)
        `CHK(width, x)
        `CHK(ee_pres, e)
        @(posedge i_mclk);
        ee_in <= ~d;
        ee_strap <= ~e;
        repeat (2) @(posedge i_mclk);
        #1;
        `CHK(width, x)
        `CHK(ee_pres, e)
    endtask
    // Sync write and read, sync write refused when unqualified or off the base, then async write, refused off the base
    task automatic t_sync();
        acc(1'b0, HIT, 1'b0, 1'b1, 0);
        `CHK(nw, 1)
        `CHK(nr, 0)
        acc(1'b0, HIT, 1'b0, 1'b0, 2);
        `CHK(nw, 0)
        `CHK(nr, 1)
        acc(1'b0, HIT, 1'b1, 1'b1, 0);
        `CHK(nw, 0)
        acc(1'b0, MISS, 1'b0, 1'b1, 0);
        `CHK(nw, 0)
        acc(1'b1, HIT, 1'b0, 1'b0, 3);
        `CHK(na, 1)
        `CHK(nw, 0)
        acc(1'b1, MISS, 1'b0, 1'b0, 1);
        `CHK(na, 0)
    endtask
    // Live decode, then decode from the latched address after pins are released
    task automatic t_decode();
        host.put(MISS, 1'b0);
        @(negedge i_mclk);
        `CHK(sel_n, 1'b1)
        host.put(HIT, 1'b0);
        @(negedge i_mclk);
        `CHK(sel_n, 1'b0)
        @(posedge i_mclk);
        host.drop();
        latch_mode <= 1'b1;
        host.latch(HIT, 1'b0);
        @(negedge i_mclk);
        `CHK(sel_n, 1'b0)
        host.latch(HIT, 1'b1);
        // Live pins now match, so only the latched qualifier can keep the select off
        host.put(HIT, 1'b0);
        @(negedge i_mclk);
        `CHK(sel_n, 1'b1)
        @(posedge i_mclk);
        latch_mode <= 1'b0;
        host.drop();
    endtask
    // Power-down follows the pin one cycle late
    task automatic t_pd(input logic v);
        @(posedge i_mclk);
        pd_n <= v;
        @(posedge i_mclk);
        #1;
        `CHK(pd, ~v)
    endtask
    // Free-running 20 MHz clock
    // The board's 25MHz reference clock lies outside this block; nothing here uses it
    initial
    begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    // Cut a hang short well past the expected run length
    initial
    begin
        repeat (3000) @(posedge i_mclk);
        err_count++;
        test_done();
    end
    // Main sequence
    initial
    begin
        i_hw_reset_n = 1'b0;
        {ee_strap, ee_in, b32, latch_mode} = 4'h0;
        pd_n = 1'b1;
        base = 16'hA5C0;
        t_strap(1'b0, 1'b0, 1'b0, BW_8);
        t_strap(1'b0, 1'b0, 1'b1, BW_16);
        t_strap(1'b1, 1'b0, 1'b0, BW_32);
        t_strap(1'b0, 1'b1, 1'b0, BW_16);
        t_sync();
        t_decode();
        t_pd(1'b0);
        t_pd(1'b1);
        test_done();
    end
endmodule
`default_nettype wire

// File: verilog/hbpc_pkg.sv
// Shared constants and types for the host bus pin control block
package hbpc_pkg;
    // Address pin span carried by the block (A15..A1)
    localparam int ADDR_W = 15;
    // Lowest address bit that takes part in the device decode (A4)
    localparam int DEC_LSB = 4;
    // Width of the programmed base address
    localparam int BASE_W = 16;
    // Clock rate of i_mclk
    localparam int CLK_HZ = 20000000;
    // Least hold time of hardware reset after the supply is stable, in ms
    localparam int RESET_MIN_MS = 10;
    // Same hold time in clock cycles, rounded down
    localparam int RESET_MIN_CYC = (CLK_HZ / 1000) * RESET_MIN_MS;

    // Address pins together with their qualifier
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic qual_n;
    } hbpc_addr_t;

    // Bus width, one-hot
    typedef enum logic [2:0] {
        BW_8 = 3'h1,
        BW_16 = 3'h2,
        BW_32 = 3'h4
    } hbpc_width_t;

    // Strap sampling state, one-hot
    typedef enum logic [1:0] {
        ST_RESET = 2'h1,
        ST_RUN = 2'h2
    } hbpc_state_t;

    // Reset values of pin history and status outputs
    localparam hbpc_addr_t ADDR_RST = '{addr: 15'h0000, qual_n: 1'b1};
    localparam logic WR_N_RST = 1'b1;
    localparam logic ADS_N_RST = 1'b0;
    localparam logic PD_RST = 1'b0;
    localparam hbpc_width_t WIDTH_RST = BW_16;
endpackage

// File: verilog/hbpc_top.sv
// Control pins of the non-PCI host bus port: straps, decode, strobes, power-down
//
// How it works
// - Data-in pin strap, with 32-bit strap low and no EEPROM: low 8-bit, high 16-bit
// - Sync access: select high writes, low reads
// - Decode only while qualifier is low
// - Active-low async strobe performs the write
// - Latch address and qualifier on strobe rise
// - Power-down while power-down input is low
// - Select output decodes qualifier and A15-A4 match
// - EEPROM absent when its strap is low
`timescale 1ns/1ns
`default_nettype none
module hbpc_top
#(
    // Width used when an EEPROM is fitted, the 32-bit strap is low and the data-in pin is not a strap
    parameter hbpc_pkg::hbpc_width_t EEPROM_WIDTH = hbpc_pkg::BW_16
)
(
    // Clock and reset (the hardware reset pin)
    input wire logic i_mclk,
    input wire logic i_hw_reset_n,
    // Straps and configuration
    input wire logic i_eeprom_present_strap,
    input wire logic i_eeprom_serial_in,
    input wire logic i_bus32_strap,
    input wire logic i_latch_mode,
    input wire logic [hbpc_pkg::BASE_W-1:0] i_base_addr,
    // Host control pins
    input wire hbpc_pkg::hbpc_addr_t i_addr,
    input wire logic i_sync_cycle,
    input wire logic i_sync_write_read_sel,
    input wire logic i_async_write_strobe_n,
    input wire logic i_addr_latch_strobe_n,
    input wire logic i_chip_powerdown_n,
    // Decode and access outputs
    output logic o_local_device_select_n,
    output logic o_sync_wr,
    output logic o_sync_rd,
    output logic o_async_wr,
    // Status outputs
    output logic o_powerdown,
    output var hbpc_pkg::hbpc_width_t o_bus_width,
    output logic o_eeprom_present,
    output logic o_strap_valid
);
    import hbpc_pkg::*;

    // Base address match on A15..A4
    function automatic logic addr_match(input hbpc_addr_t a, input logic [BASE_W-1:0] base);
        addr_match = (a.addr[ADDR_W-1:DEC_LSB-1] == base[BASE_W-1:DEC_LSB]);
    endfunction

    // Width picked from the straps
    function automatic hbpc_width_t strap_width(input logic b32, input logic ee, input logic di);
        if (b32)
            strap_width = BW_32;
        else if (ee)
            strap_width = EEPROM_WIDTH;
        else if (di)
            strap_width = BW_16;
        else
            strap_width = BW_8;
    endfunction

    hbpc_state_t state; // Strap sampling state
    hbpc_state_t next_state;
    hbpc_width_t next_bus_width;
    logic next_eeprom_present;
    hbpc_addr_t latched; // Address captured by the latch strobe
    hbpc_addr_t next_latched;
    logic ads_n_q; // Previous latch strobe level
    logic wr_n_q; // Previous async write strobe level
    hbpc_addr_t eff_addr; // Address seen by the decode
    logic selected; // Device is addressed
    logic next_sync_wr;
    logic next_sync_rd;
    logic next_async_wr;
    logic next_powerdown;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_hw_reset_n);

    // Strap sampling: the first cycle after release takes the pins once
    always_comb
    begin
        next_state = state;
        next_bus_width = o_bus_width;
        next_eeprom_present = o_eeprom_present;
        case (state)
            ST_RESET:
            begin
                // Straps settle under reset, so sampling waits for release
                next_eeprom_present = i_eeprom_present_strap;
                next_bus_width = strap_width(i_bus32_strap, i_eeprom_present_strap,
                                             i_eeprom_serial_in);
                next_state = ST_RUN;
            end
            ST_RUN:
            begin
                // Held until the next reset
                next_state = ST_RUN;
            end
            default:
            begin
                next_state = ST_RESET;
            end
        endcase
    end

    // Strap registers
    always_ff @(posedge i_mclk)
    begin
        if (!i_hw_reset_n)
        begin
            state <= ST_RESET;
            o_bus_width <= WIDTH_RST;
            o_eeprom_present <= 1'b0;
            o_strap_valid <= 1'b0;
        end
        else
        begin
            state <= next_state;
            o_bus_width <= next_bus_width;
            o_eeprom_present <= next_eeprom_present;
            o_strap_valid <= (next_state == ST_RUN);
        end
    end

    // Address latch capture on the rising edge of the latch strobe
    always_comb
    begin
        next_latched = latched;
        if (!ads_n_q && i_addr_latch_strobe_n)
        begin
            next_latched = i_addr;
        end
    end

    // Decode source: latched or live pins
    always_comb
    begin
        eff_addr = i_latch_mode ? latched : i_addr;
        selected = !eff_addr.qual_n && addr_match(eff_addr, i_base_addr);
    end

    // Select output is a pure gate decode; registering it would cost the host a cycle
    assign o_local_device_select_n = !selected;

    // Access strobes and power-down
    always_comb
    begin
        next_sync_wr = selected && i_sync_cycle && i_sync_write_read_sel;
        next_sync_rd = selected && i_sync_cycle && !i_sync_write_read_sel;
        // Falling edge only, so a held-low strobe writes once
        next_async_wr = selected && wr_n_q && !i_async_write_strobe_n;
        next_powerdown = !i_chip_powerdown_n;
    end

    // Pin history and access registers
    always_ff @(posedge i_mclk)
    begin
        if (!i_hw_reset_n)
        begin
            latched <= ADDR_RST;
            ads_n_q <= ADS_N_RST;
            wr_n_q <= WR_N_RST;
            o_sync_wr <= 1'b0;
            o_sync_rd <= 1'b0;
            o_async_wr <= 1'b0;
            o_powerdown <= PD_RST;
        end
        else
        begin
            latched <= next_latched;
            ads_n_q <= i_addr_latch_strobe_n;
            wr_n_q <= i_async_write_strobe_n;
            o_sync_wr <= next_sync_wr;
            o_sync_rd <= next_sync_rd;
            o_async_wr <= next_async_wr;
            o_powerdown <= next_powerdown;
        end
    end

    // Width strap taken at the first cycle out of reset; the reset edge itself is
    // left out so the check never compares against the reset value of the width
    a_width_strap: assert property ((i_hw_reset_n && state == ST_RESET) |=> o_bus_width ==
        strap_width($past(i_bus32_strap), $past(i_eeprom_present_strap),
        $past(i_eeprom_serial_in)))
        else $error("bus width does not follow straps");

    // Sync write needs a selected cycle with select high
    a_sync_write: assert property ($rose(o_sync_wr) |-> $past(i_sync_write_read_sel)
        && $past(i_sync_cycle) && $past(selected))
        else $error("sync write without write select");

    // Sync read with select low, never both at once
    a_sync_read: assert property ((selected && i_sync_cycle && !i_sync_write_read_sel)
        |=> o_sync_rd && !o_sync_wr)
        else $error("sync read not issued");

    // Qualifier high blocks selection
    a_qual_blocks: assert property (eff_addr.qual_n |-> o_local_device_select_n)
        else $error("select while qualifier high");

    // Async write one cycle after a selected falling strobe, for one cycle
    a_async_write: assert property ((selected && $fell(i_async_write_strobe_n))
        |=> o_async_wr ##1 !o_async_wr)
        else $error("async write pulse wrong");

    // Latch takes the address at a strobe rise and keeps it the cycle after
    a_latch_capture: assert property ($rose(i_addr_latch_strobe_n) |=>
        latched == $past(i_addr) ##1 $stable(latched))
        else $error("latched address wrong");

    // Power-down follows the pin with one cycle delay, once out of reset
    a_powerdown_pin: assert property (i_hw_reset_n |=>
        o_powerdown == !$past(i_chip_powerdown_n))
        else $error("power-down does not follow pin");

    // Select decode against the base address
    a_select_decode: assert property ((!eff_addr.qual_n && eff_addr.addr[14:3]
        == i_base_addr[15:4]) |-> !o_local_device_select_n)
        else $error("select not asserted on match");

    // EEPROM absent when its strap was low at sampling
    a_eeprom_absent: assert property ((state == ST_RESET && !i_eeprom_present_strap)
        |=> !o_eeprom_present)
        else $error("EEPROM present with strap low");

    // Straps stay fixed once sampled
    a_strap_hold: assert property (o_strap_valid |=> $stable(o_bus_width)
        && $stable(o_eeprom_present) && o_strap_valid)
        else $error("strap values changed after sampling");
endmodule
`default_nettype wire
